// ==== inc/pmrc_params.svh ====
/*
 * named figures of the power mode and reset controller: clock rate,
 * divider ratios, reset qualification length, oscillator start time,
 * power control bit positions and counter widths.
 * assumes it is included by bare name by every file that needs a figure.
 */
`ifndef PMRC_PARAMS_SVH
`define PMRC_PARAMS_SVH

// ****************************************************************
// clocking
// ****************************************************************
`define PMRC_CLK_MHZ        10
`define PMRC_STATES_PER_MC  3'h6
`define PMRC_MC_LAST        3'h5
// ****************************************************************
// reset timing
// ****************************************************************
`define PMRC_RST_QUAL_OSC   5'h18
`define PMRC_QUAL_W         5
`define PMRC_WDT_RST_MC     2'h2
// oscillator restart time in microseconds, then in clock cycles
`define PMRC_OSC_START_US   2000
`define PMRC_OSC_START_CYC  (`PMRC_OSC_START_US * `PMRC_CLK_MHZ)
`define PMRC_WAKE_W         16
// ****************************************************************
// power control register layout
// ****************************************************************
`define PMRC_POWER_CONTROL_REGISTER_W         2
`define PMRC_POWER_CONTROL_REGISTER_IDLE      0
`define PMRC_POWER_CONTROL_REGISTER_PD        1
`define PMRC_POWER_CONTROL_REGISTER_RESET     2'h0

`endif

// ==== inc/pmrc_pkg.sv ====
/*
 * types of the power mode and reset controller: the mode state machine.
 * assumes pmrc_params.svh holds every figure; this package holds only types.
 */
package pmrc_pkg;

  // ****************************************************************
  // operating modes, one-hot
  // ****************************************************************
  typedef enum logic [5:0] {
    PMRC_RUN      = 6'h01,  // core executing
    PMRC_IDLE     = 6'h02,  // core halted, peripherals run
    PMRC_IDLE_RST = 6'h04,  // reset pin seen in idle, core briefly resumes
    PMRC_PDOWN    = 6'h08,  // oscillator stopped
    PMRC_WAKE     = 6'h10,  // oscillator restarting
    PMRC_RESET    = 6'h20   // internal reset active
  } pmrc_state_t;

endpackage

// ==== rtl/pmrc_clk_div.sv ====
/*
 * divide-by-two state clock and machine cycle enables.
 * assumes core_clk is the oscillator clock and osc_stable is low while
 * the oscillator is stopped or still starting.
 */
`timescale 1ns/1ps
`include "pmrc_params.svh"

module pmrc_clk_div (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic osc_stable,
  output logic      state_tick,
  output logic      mc_tick
);
  import pmrc_pkg::*;

  logic       phase;   // divide-by-two flip-flop
  logic [2:0] st_cnt;  // state count within a machine cycle

  // ****************************************************************
  // divider
  // ****************************************************************
  // tick only on every second oscillator edge, so duty cycle is irrelevant
  assign state_tick = phase & osc_stable;
  assign mc_tick    = state_tick & (st_cnt == `PMRC_MC_LAST);

  // toggle flop runs only while the oscillator runs
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      phase <= 1'b0;
    else if (osc_stable)
      phase <= ~phase;
  end

  // count states to mark machine cycles
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      st_cnt <= 3'h0;
    else if (mc_tick)
      st_cnt <= 3'h0;
    else if (state_tick)
      st_cnt <= st_cnt + 3'h1;
  end

endmodule

// ==== rtl/pmrc_rst_qual.sv ====
/*
 * reset pin qualifier: the pin must stay high for a full count of running
 * oscillator periods before a reset is recognised.
 * assumes rst_pin is synchronous to core_clk.
 */
`timescale 1ns/1ps
`include "pmrc_params.svh"

module pmrc_rst_qual (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic osc_stable,
  input  wire logic rst_pin,
  output logic      qualified
);
  import pmrc_pkg::*;

  logic [`PMRC_QUAL_W-1:0] cnt;       // running periods with pin high
  logic [7:0]              chk_run;   // helper for the check below
  wire                     cnt_full = (cnt == `PMRC_RST_QUAL_OSC);
  wire                     cnt_last = (cnt == `PMRC_RST_QUAL_OSC - 5'h1);  // final period now

  // ****************************************************************
  // qualification counter
  // ****************************************************************
  // count high pin only while oscillator runs
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      cnt <= '0;
    else if (!rst_pin)
      cnt <= '0;
    else if (osc_stable && !cnt_full)
      cnt <= cnt + 5'h1;
  end

  // last counted period qualifies at once
  // level then stays while the pin stays high
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      qualified <= 1'b0;
    else
      qualified <= rst_pin & (cnt_full | (osc_stable & cnt_last));
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      chk_run <= 8'h0;
    else if (!rst_pin)
      chk_run <= 8'h0;
    else if (osc_stable && chk_run != 8'hff)
      chk_run <= chk_run + 8'h1;
  end

  property p_qual_len;
    @(posedge core_clk) disable iff (reset)
    $rose(qualified) |-> (chk_run >= 8'(`PMRC_RST_QUAL_OSC));
  endproperty
  a_qual_len: assert property (p_qual_len) else $error("reset qualified too early");

endmodule

// ==== rtl/pmrc_top.sv ====
/*
 * power mode and reset controller: idle and power-down modes, wake-up,
 * reset pin qualification, watchdog reset, oscillator gating and the
 * pin states held in each mode.
 * assumes the core pulses instr_done as each instruction completes and
 * writes the power control bits with power_control_register_wr; all inputs are synchronous.
 */
// Overview of operation
// - reset needs pin high 24 running periods
// - input clock divided by two internally
// - idle halts core, peripherals and state kept
// - idle entered after requesting instruction completes
// - enabled interrupt or reset ends idle
// - power-down stops oscillator after request instruction
// - reset or external interrupt ends power-down
// - interrupt wake keeps memory and registers
// - wake interrupt must be level and enabled
// - interrupt wake resumes at next instruction
// - watchdog reset ends power-down like reset
// - mode request bits sit in power control
// - reset from idle blocks RAM, not ports
// - idle drives both strobes high
// - power-down drives both strobes low
`timescale 1ns/1ps
`include "pmrc_params.svh"

module pmrc_top #(
  parameter logic [`PMRC_WAKE_W-1:0] OSC_START_CYC = `PMRC_WAKE_W'(`PMRC_OSC_START_CYC)
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     rst_pin,
  input  wire logic                     wdt_reset,
  input  wire logic                     power_control_register_wr,
  input  wire logic [`PMRC_POWER_CONTROL_REGISTER_W-1:0]  power_control_register_wdata,
  input  wire logic                     instr_done,
  input  wire logic                     irq_enabled_pending,
  input  wire logic                     ext_irq_zero,
  input  wire logic                     ext_irq_one,
  input  wire logic                     ext_irq_zero_level,
  input  wire logic                     ext_irq_one_level,
  input  wire logic                     ext_irq_zero_en,
  input  wire logic                     ext_irq_one_en,
  input  wire logic                     ext_prog_mem,
  input  wire logic                     core_ale,
  input  wire logic                     core_program_fetch_strobe,
  output logic [`PMRC_POWER_CONTROL_REGISTER_W-1:0]       power_control_register,
  output pmrc_pkg::pmrc_state_t         mode_state,
  output logic                          osc_enable,
  output logic                          cpu_clk_en,
  output logic                          periph_clk_en,
  output logic                          internal_reset,
  output logic                          ram_access_block,
  output logic                          ale_out,
  output logic                          program_fetch_strobe,
  output logic                          port0_drive_en,
  output logic                          port2_addr_sel
);
  import pmrc_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  pmrc_state_t              state;          // current mode
  pmrc_state_t              next_state;     // mode for next edge
  logic                     wake_by_rst;    // power-down left via reset pin
  logic [`PMRC_WAKE_W-1:0]  wake_cnt;       // oscillator restart timer
  logic [1:0]               rst_mc;         // machine cycles spent in reset
  logic                     state_tick;     // divided clock enable
  logic                     mc_tick;        // machine cycle enable
  logic                     rst_qual;       // reset pin qualified
  logic [`PMRC_POWER_CONTROL_REGISTER_W-1:0]  next_power_control_register;      // power control next value
  logic                     next_ale;       // strobe next values
  logic                     next_program_fetch_strobe;
  logic                     next_p0;
  logic                     next_p2;

  // external interrupt may wake only when level mode, enabled and low
  function automatic logic irq_wakes(input logic pin, input logic level,
                                     input logic en);
    irq_wakes = !pin & level & en;
  endfunction

  // ****************************************************************
  // decoding
  // ****************************************************************
  // only level-sensitive enabled inputs wake
  wire wake_irq   = irq_wakes(ext_irq_zero, ext_irq_zero_level, ext_irq_zero_en)
                  | irq_wakes(ext_irq_one, ext_irq_one_level, ext_irq_one_en);
  wire in_run     = (state == PMRC_RUN);
  wire in_idle    = (state == PMRC_IDLE);
  wire in_idlerst = (state == PMRC_IDLE_RST);
  wire in_pdown   = (state == PMRC_PDOWN);
  wire in_wake    = (state == PMRC_WAKE);
  wire in_reset   = (state == PMRC_RESET);
  // oscillator runs and is usable outside power-down and restart
  wire osc_stable = !(in_pdown || in_wake);
  wire wake_done  = in_wake && (wake_cnt == OSC_START_CYC - `PMRC_WAKE_W'(1));
  wire rst_held   = (rst_mc == `PMRC_WDT_RST_MC);
  wire req_pd     = instr_done && power_control_register[`PMRC_POWER_CONTROL_REGISTER_PD];
  wire req_idle   = instr_done && power_control_register[`PMRC_POWER_CONTROL_REGISTER_IDLE];

  assign osc_enable    = !in_pdown;
  assign periph_clk_en = state_tick;
  assign cpu_clk_en    = state_tick & (in_run | in_idlerst);
  assign mode_state    = state;

  // ****************************************************************
  // submodules
  // ****************************************************************
  // divide-by-two state clock
  pmrc_clk_div u_div (
    .core_clk   (core_clk),
    .reset      (reset),
    .osc_stable (osc_stable),
    .state_tick (state_tick),
    .mc_tick    (mc_tick)
  );

  pmrc_rst_qual u_qual (
    .core_clk   (core_clk),
    .reset      (reset),
    .osc_stable (osc_stable),
    .rst_pin    (rst_pin),
    .qualified  (rst_qual)
  );

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      PMRC_RUN:
      begin
        if (rst_qual || wdt_reset)
          next_state = PMRC_RESET;
        else if (req_pd)
          next_state = PMRC_PDOWN;
        else if (req_idle)
          next_state = PMRC_IDLE;
      end
      PMRC_IDLE:
      begin
        if (wdt_reset)
          next_state = PMRC_RESET;
        // reset pin lets core resume briefly
        else if (rst_pin)
          next_state = PMRC_IDLE_RST;
        else if (irq_enabled_pending)
          next_state = PMRC_RUN;
      end
      PMRC_IDLE_RST:
      begin
        if (rst_qual || wdt_reset)
          next_state = PMRC_RESET;
        else if (!rst_pin)
          next_state = PMRC_RUN;
      end
      PMRC_PDOWN:
      begin
        if (wdt_reset)
          next_state = PMRC_RESET;
        // reset pin or external interrupt wakes
        else if (rst_pin || wake_irq)
          next_state = PMRC_WAKE;
      end
      PMRC_WAKE:
      begin
        if (wdt_reset)
          next_state = PMRC_RESET;
        else if (wake_done)
          next_state = PMRC_RUN;
      end
      PMRC_RESET:
      begin
        // held while pin stays qualified, until two machine cycle ticks have been counted
        if (!rst_qual && rst_held)
          next_state = PMRC_RUN;
      end
      default:
        next_state = PMRC_RESET;
    endcase
  end

  // state register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      state <= PMRC_RESET;
    else
      state <= next_state;
  end

  // remember whether the restart came from the reset pin
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      wake_by_rst <= 1'b0;
    else if (in_pdown)
      wake_by_rst <= rst_pin;
  end

  // oscillator restart timer
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      wake_cnt <= '0;
    else if (in_wake)
      wake_cnt <= wake_cnt + `PMRC_WAKE_W'(1);
    else
      wake_cnt <= '0;
  end

  // machine cycles spent in internal reset
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      rst_mc <= 2'h0;
    else if (!in_reset)
      rst_mc <= 2'h0;
    else if (mc_tick && !rst_held)
      rst_mc <= rst_mc + 2'h1;
  end

  // ****************************************************************
  // power control register
  // ****************************************************************
  // mode bits held here; hardware clears on exit, write wins
  always_comb
  begin
    next_power_control_register = power_control_register;
    if (in_idle && next_state != PMRC_IDLE)
      next_power_control_register[`PMRC_POWER_CONTROL_REGISTER_IDLE] = 1'b0;
    // interrupt wake clears only pd bit
    if (in_wake && next_state != PMRC_WAKE)
      next_power_control_register[`PMRC_POWER_CONTROL_REGISTER_PD] = 1'b0;
    if (power_control_register_wr)
      next_power_control_register = power_control_register_wdata;
    // any reset clears the power control register
    if (next_state == PMRC_RESET)
      next_power_control_register = `PMRC_POWER_CONTROL_REGISTER_RESET;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      power_control_register <= `PMRC_POWER_CONTROL_REGISTER_RESET;
    else
      power_control_register <= next_power_control_register;
  end

  // ****************************************************************
  // pin states per mode
  // ****************************************************************
  // strobe and port states by mode
  always_comb
  begin
    next_ale  = core_ale;
    next_program_fetch_strobe = core_program_fetch_strobe;
    next_p0   = 1'b1;
    next_p2   = ext_prog_mem;
    unique case (next_state)
      PMRC_IDLE:
      begin
        next_ale  = 1'b1;
        next_program_fetch_strobe = 1'b1;
        next_p0   = !ext_prog_mem;
      end
      PMRC_PDOWN, PMRC_WAKE:
      begin
        next_ale  = 1'b0;
        next_program_fetch_strobe = 1'b0;
        next_p0   = !ext_prog_mem;
        next_p2   = 1'b0;
      end
      PMRC_RESET:
      begin
        next_ale  = 1'b1;
        next_program_fetch_strobe = 1'b1;
        next_p0   = 1'b0;
        next_p2   = 1'b0;
      end
      PMRC_RUN, PMRC_IDLE_RST:
      begin
        next_p0   = 1'b1;
      end
      default:
      begin
        next_p0   = 1'b0;
      end
    endcase
  end

  // registered pin and reset outputs, aligned with state
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ale_out              <= 1'b1;
      program_fetch_strobe <= 1'b1;
      port0_drive_en       <= 1'b0;
      port2_addr_sel       <= 1'b0;
      internal_reset       <= 1'b1;
      ram_access_block     <= 1'b0;
    end
    else
    begin
      ale_out              <= next_ale;
      program_fetch_strobe <= next_program_fetch_strobe;
      port0_drive_en       <= next_p0;
      port2_addr_sel       <= next_p2;
      internal_reset       <= (next_state == PMRC_RESET);
      // block RAM while core resumes from idle
      ram_access_block     <= (next_state == PMRC_IDLE_RST);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_idle_entry;
    !in_idle ##1 in_idle;
  endsequence
  sequence s_ext_wake;
    in_pdown && !rst_pin && !wdt_reset && wake_irq ##1 in_wake;
  endsequence

  property p_idle_entry;
    @(posedge core_clk) disable iff (reset)
    s_idle_entry |-> $past(instr_done) && $past(power_control_register[`PMRC_POWER_CONTROL_REGISTER_IDLE]);
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle without request");

  property p_idle_halt;
    @(posedge core_clk) disable iff (reset)
    in_idle |-> !cpu_clk_en && (periph_clk_en == state_tick);
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("core clocked in idle");

  property p_idle_irq;
    @(posedge core_clk) disable iff (reset)
    in_idle && irq_enabled_pending && !rst_pin && !wdt_reset |=> in_run ##1 !in_idle;
  endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("interrupt did not end idle");

  property p_div2;
    @(posedge core_clk) disable iff (reset)
    state_tick |=> !state_tick;
  endproperty
  a_div2: assert property (p_div2) else $error("state tick not halved");

  property p_pd_osc;
    @(posedge core_clk) disable iff (reset)
    $rose(in_pdown) |-> !osc_enable && $past(req_pd);
  endproperty
  a_pd_osc: assert property (p_pd_osc) else $error("oscillator ran in power-down");

  property p_pd_src;
    @(posedge core_clk) disable iff (reset)
    in_pdown ##1 in_wake |-> $past(rst_pin) || $past(wake_irq);
  endproperty
  a_pd_src: assert property (p_pd_src) else $error("wake without source");

  property p_ext_keep;
    @(posedge core_clk) disable iff (reset)
    s_ext_wake |-> !internal_reset && power_control_register[`PMRC_POWER_CONTROL_REGISTER_PD] && !wake_by_rst;
  endproperty
  a_ext_keep: assert property (p_ext_keep) else $error("interrupt wake disturbed state");

  property p_wdt_pd;
    @(posedge core_clk) disable iff (reset)
    in_pdown && wdt_reset |=> in_reset && internal_reset && osc_enable;
  endproperty
  a_wdt_pd: assert property (p_wdt_pd) else $error("watchdog missed power-down");

  property p_ram_block;
    @(posedge core_clk) disable iff (reset)
    in_idlerst |-> ram_access_block && (cpu_clk_en == state_tick);
  endproperty
  a_ram_block: assert property (p_ram_block) else $error("ram open in idle reset");

  property p_idle_pins;
    @(posedge core_clk) disable iff (reset)
    in_idle |-> ale_out && program_fetch_strobe && (port0_drive_en != $past(ext_prog_mem));
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle strobes wrong");

  property p_pd_pins;
    @(posedge core_clk) disable iff (reset)
    in_pdown |-> !ale_out && !program_fetch_strobe && !port2_addr_sel;
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("power-down strobes wrong");

  property p_power_control_register_wr;
    @(posedge core_clk) disable iff (reset)
    power_control_register_wr && in_run && !rst_qual && !wdt_reset |=> power_control_register == $past(power_control_register_wdata);
  endproperty
  a_power_control_register_wr: assert property (p_power_control_register_wr) else $error("power control write lost");

  property p_wake_len;
    @(posedge core_clk) disable iff (reset)
    s_ext_wake |-> in_wake [*8];
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake too short");

endmodule

// ==== tb/pmrc_partner.sv ====
/*
 * far-side model: reset source and the two external interrupt lines.
 * assumes the bench calls its tasks at a falling edge of core_clk.
 */
`timescale 1ns/1ps

module pmrc_partner (
  input  wire logic core_clk,
  output logic      rst_pin,
  output logic      ext_irq_zero,
  output logic      ext_irq_one
);
  // released levels: reset pulled down, irq lines pulled up
  initial
  begin
    rst_pin      = 1'b0;
    ext_irq_zero = 1'b1;
    ext_irq_one  = 1'b1;
  end
  // pin held high a counted span
  task automatic pulse_rst(input int n);
    rst_pin = 1'b1;
    repeat (n) @(negedge core_clk);
    rst_pin = 1'b0;
  endtask
  task automatic irq_low(input int w, input int n);
    if (w == 0)
      ext_irq_zero = 1'b0;
    else
      ext_irq_one = 1'b0;
    repeat (n) @(negedge core_clk);
    ext_irq_zero = 1'b1;
    ext_irq_one  = 1'b1;
  endtask
endmodule

// ==== tb/pmrc_top_tb.sv ====
/*
 * self-checking bench: reset, idle, power-down and the wake paths.
 * assumes pmrc_partner drives the reset pin and the irq lines.
 */
`timescale 1ns/1ps
`include "pmrc_params.svh"

module pmrc_top_tb;
  import pmrc_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int           WAKE = 16;  // shortened oscillator restart
  logic                    core_clk, reset, wdt_reset, power_control_register_wr, instr_done, irq_pend;
  logic                    ext_pm, z_lvl, o_lvl, z_en, o_en, core_st;
  logic [`PMRC_POWER_CONTROL_REGISTER_W-1:0] power_control_register_wdata, pcr;
  logic                    osc_en, cpu_en, per_en, int_rst, ram_blk, ale_o, program_fetch_strobe_o;
  logic                    p0_en, p2_sel, rst_pin, irq_z, irq_o;
  pmrc_state_t             mode;
  int                      err_count = 0;
  int                      n_checks = 0;

  pmrc_top #(.OSC_START_CYC(`PMRC_WAKE_W'(WAKE))) dut (
    .core_clk(core_clk), .reset(reset), .rst_pin(rst_pin), .wdt_reset(wdt_reset),
    .power_control_register_wr(power_control_register_wr), .power_control_register_wdata(power_control_register_wdata), .instr_done(instr_done),
    .irq_enabled_pending(irq_pend), .ext_irq_zero(irq_z), .ext_irq_one(irq_o),
    .ext_irq_zero_level(z_lvl), .ext_irq_one_level(o_lvl), .ext_irq_zero_en(z_en),
    .ext_irq_one_en(o_en), .ext_prog_mem(ext_pm), .core_ale(core_st), .core_program_fetch_strobe(core_st),
    .power_control_register(pcr), .mode_state(mode), .osc_enable(osc_en),
    .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .internal_reset(int_rst),
    .ram_access_block(ram_blk), .ale_out(ale_o), .program_fetch_strobe(program_fetch_strobe_o),
    .port0_drive_en(p0_en), .port2_addr_sel(p2_sel));

  pmrc_partner partner (.core_clk(core_clk), .rst_pin(rst_pin),
    .ext_irq_zero(irq_z), .ext_irq_one(irq_o));

  // ****************************************************************
  // helpers
  // ****************************************************************
  // clock, 100 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic summarize();
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // bounded wait for a mode
  task automatic wait_mode(input pmrc_state_t m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++)
      cyc(1);
  endtask
  // write power control bits, then finish an instruction
  task automatic enter(input logic [1:0] bits);
    power_control_register_wr = 1'b1;
    power_control_register_wdata = bits;
    cyc(1);
    power_control_register_wr = 1'b0;
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    check(8'(mode), 8'(PMRC_RESET));
    check(8'({int_rst, osc_en, ale_o, program_fetch_strobe_o, p0_en}), 8'h1e);
    reset = 1'b0;
    wait_mode(PMRC_RUN, 40);
    check(8'({mode, int_rst}), 8'({PMRC_RUN, 1'b0}));
  endtask
  task automatic t_idle();
    int cpu_n = 0;
    int per_n = 0;
    ext_pm = 1'b1;
    enter(2'h1);
    check(8'(mode), 8'(PMRC_IDLE));
    check(8'(pcr), 8'h01);
    check(8'({ale_o, program_fetch_strobe_o, p0_en, p2_sel}), 8'h0d);
    repeat (4)
    begin
      cyc(1);
      cpu_n += int'(cpu_en === 1'b1);
      per_n += int'(per_en === 1'b1);
    end
    check(8'(cpu_n), 8'h00);
    check(8'(per_n), 8'h02);
    irq_pend = 1'b1;
    cyc(1);
    irq_pend = 1'b0;
    check(8'({mode, pcr}), 8'({PMRC_RUN, 2'h0}));
  endtask
  task automatic t_idle_rst();
    ext_pm = 1'b0;
    enter(2'h1);
    check(8'({p0_en, p2_sel}), 8'h02);
    fork
      partner.pulse_rst(40);
    join_none
    cyc(1);
    check(8'({mode, ram_blk}), 8'({PMRC_IDLE_RST, 1'b1}));
    wait_mode(PMRC_RESET, 40);
    check(8'({mode, int_rst, ram_blk}), 8'({PMRC_RESET, 2'h2}));
    wait_mode(PMRC_RUN, 80);
    check(8'({mode, pcr}), 8'({PMRC_RUN, 2'h0}));
  endtask
  task automatic t_rst_len();
    partner.pulse_rst(23);
    cyc(4);
    check(8'({mode, int_rst}), 8'({PMRC_RUN, 1'b0}));
    fork
      partner.pulse_rst(24);
    join_none
    wait_mode(PMRC_RESET, 30);
    check(8'({mode, int_rst}), 8'({PMRC_RESET, 1'b1}));
    wait_mode(PMRC_RUN, 60);
  endtask
  task automatic t_pdown(input int w);
    ext_pm = 1'b1;
    core_st = 1'b1;
    enter(2'h2);
    check(8'(mode), 8'(PMRC_PDOWN));
    check(8'({osc_en, ale_o, program_fetch_strobe_o, p0_en, p2_sel}), 8'h00);
    {z_lvl, o_lvl, z_en, o_en} = 4'h3;
    partner.irq_low(w, 4);
    cyc(1);
    {z_lvl, o_lvl, z_en, o_en} = 4'hc;
    partner.irq_low(w, 4);
    check(8'(mode), 8'(PMRC_PDOWN));
    {z_en, o_en} = 2'h3;
    cyc(1);
    fork
      partner.irq_low(w, WAKE + 4);
    join_none
    cyc(1);
    check(8'({mode, osc_en, int_rst}), 8'({PMRC_WAKE, 2'h2}));
    wait_mode(PMRC_RUN, WAKE + 4);
    check(8'({mode, int_rst}), 8'({PMRC_RUN, 1'b0}));
    check(8'({pcr, p0_en, p2_sel, ale_o, program_fetch_strobe_o}), 8'h0f);
    cyc(6);
  endtask
  task automatic t_wdt();
    enter(2'h3);
    check(8'(mode), 8'(PMRC_PDOWN));
    wdt_reset = 1'b1;
    cyc(1);
    wdt_reset = 1'b0;
    check(8'({mode, int_rst}), 8'({PMRC_RESET, 1'b1}));
    wait_mode(PMRC_RUN, 40);
    check(8'({mode, pcr}), 8'({PMRC_RUN, 2'h0}));
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    {reset, wdt_reset, power_control_register_wr, instr_done, irq_pend, ext_pm, core_st} = 7'h40;
    {z_lvl, o_lvl, z_en, o_en, power_control_register_wdata} = 6'h00;
    t_reset();
    t_idle();
    t_idle_rst();
    t_rst_len();
    t_pdown(0);
    t_pdown(1);
    t_wdt();
    summarize();
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    summarize();
  end
endmodule
